/* File: lpmwb_consts.svh */
`ifndef LPMWB_CONSTS_SVH
`define LPMWB_CONSTS_SVH
// Main page register offsets.
`define LPMWB_REG_WB_CTRL    8'h2a
`define LPMWB_REG_RELOAD     8'h2b
`define LPMWB_REG_MAP        8'h2c
`define LPMWB_REG_STATUS     8'h2d
// Any write here leaves the table page.
`define LPMWB_PAGE_EXIT      8'hff
// Values written to the white-balance control register.
`define LPMWB_CMD_RED        8'h70
`define LPMWB_CMD_GREEN      8'hb0
`define LPMWB_CMD_BLUE       8'hf0
`define LPMWB_CMD_WB_ON      8'h20
`define LPMWB_CMD_WB_OFF     8'h00
// Fields of the lane map and reload control registers.
`define LPMWB_MAP_OVR_BIT    0
`define LPMWB_MAP_VAL_BIT    1
`define LPMWB_MAP_OUT18_BIT  2
`define LPMWB_MAP_IN6_BIT    3
`define LPMWB_MAP_RST        4'h0
`define LPMWB_RELOAD_BIT     0
// Frame shape: seven bit slots on each of four lanes.
`define LPMWB_SLOTS          7
`define LPMWB_LAST_SLOT      3'h6
`define LPMWB_LANES          4
`define LPMWB_FRAME_W        28
// Clock lane pattern over the seven slots, slot 0 in bit 0.
`define LPMWB_CLK_PAT        7'h63
// Width of the pin sampling vector.
`define LPMWB_SYNC_W         29
`endif

/* File: lpmwb_lut.sv */
`timescale 1ns/1ps
`default_nettype none

module lpmwb_lut (
    input  wire logic  mclk_in,
    lpmwb_lut_if.store lut
);

    // Three colour tables of 256 bytes each, held in flip-flops.
    lpmwb_pkg::lpmwb_byte_t mem [3][256];

    // Host writes; the pixel port keeps reading, so a reload is seamless.
    always_ff @(posedge mclk_in) begin
        if (lut.wr_en && lut.wr_sel != 2'h0) begin
            mem[lut.wr_sel - 2'h1][lut.addr] <= lut.wr_data;
        end
    end

    // Host read port and the three pixel lookups.
    always_comb begin
        if (lut.rd_sel != 2'h0) begin
            lut.rd_data = mem[lut.rd_sel - 2'h1][lut.addr];
        end else begin
            lut.rd_data = 8'h00;
        end
        lut.pix_r_val = mem[0][lut.pix_r_idx];
        lut.pix_g_val = mem[1][lut.pix_g_idx];
        lut.pix_b_val = mem[2][lut.pix_b_idx];
    end

endmodule : lpmwb_lut

`default_nettype wire

/* File: lpmwb_lut_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Connects the control logic with the three colour tables.
interface lpmwb_lut_if;
    logic                  wr_en;
    logic [1:0]            wr_sel;
    lpmwb_pkg::lpmwb_byte_t addr;
    lpmwb_pkg::lpmwb_byte_t wr_data;
    logic [1:0]            rd_sel;
    lpmwb_pkg::lpmwb_byte_t rd_data;
    lpmwb_pkg::lpmwb_byte_t pix_r_idx;
    lpmwb_pkg::lpmwb_byte_t pix_g_idx;
    lpmwb_pkg::lpmwb_byte_t pix_b_idx;
    lpmwb_pkg::lpmwb_byte_t pix_r_val;
    lpmwb_pkg::lpmwb_byte_t pix_g_val;
    lpmwb_pkg::lpmwb_byte_t pix_b_val;

    modport ctrl (output wr_en, wr_sel, addr, wr_data, rd_sel,
                  output pix_r_idx, pix_g_idx, pix_b_idx,
                  input  rd_data, pix_r_val, pix_g_val, pix_b_val);
    modport store (input  wr_en, wr_sel, addr, wr_data, rd_sel,
                   input  pix_r_idx, pix_g_idx, pix_b_idx,
                   output rd_data, pix_r_val, pix_g_val, pix_b_val);
endinterface : lpmwb_lut_if

`default_nettype wire

/* File: lpmwb_panel.sv */
`include "lpmwb_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Display side: rebuilds each 28-bit frame from the four serial lanes.
module lpmwb_panel (
    input  wire logic        mclk_in,
    input  wire logic [3:0]  lane_bit_in,
    input  wire logic        lane_clk_in,
    output logic      [27:0] rx_frame_out,
    output logic      [15:0] rx_count_out
);
    logic [6:0]  clk_hist = 7'h00;
    logic [6:0]  hist [4];
    logic [15:0] cnt = 16'h0000;

    assign rx_count_out = cnt;

    // Shifts every lane, oldest slot ending in bit 0.
    always @(posedge mclk_in) begin
        clk_hist <= {lane_clk_in, clk_hist[6:1]};
        for (int l = 0; l < 4; l++) begin
            hist[l] <= {lane_bit_in[l], hist[l][6:1]};
        end
    end

    // A frame is whole once the clock lane shows its 2-3-2 shape.
    always @(posedge mclk_in) begin
        if (clk_hist == `LPMWB_CLK_PAT) begin
            rx_frame_out <= {hist[3], hist[2], hist[1], hist[0]};
            cnt <= cnt + 16'h0001;
        end
    end
endmodule : lpmwb_panel

`default_nettype wire

/* File: lpmwb_pkg.sv */
package lpmwb_pkg;

    // Register page that host accesses land on.
    typedef enum logic [1:0] {
        LPMWB_PG_MAIN  = 2'b00,
        LPMWB_PG_RED   = 2'b01,
        LPMWB_PG_GREEN = 2'b10,
        LPMWB_PG_BLUE  = 2'b11
    } lpmwb_page_e;

    typedef logic [7:0] lpmwb_byte_t;

endpackage : lpmwb_pkg

/* File: lpmwb_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// Watches the register read port and the serial lanes of the top module.
module lpmwb_properties (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_rdata_out,
    input  wire logic        pclk_in,
    input  wire logic [27:0] lane_frame_out,
    input  wire logic        frame_valid_out,
    input  wire logic [3:0]  lane_bit_out,
    input  wire logic        lvds_clock_out_a,
    input  wire logic        lvds_clock_out_b
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    // Frame one cycle back, since the next frame lands during the last slot.
    logic [27:0] prev_frame_r;

    always_ff @(posedge mclk_in) begin
        prev_frame_r <= lane_frame_out;
    end

    rdata_idle_a: assert property (
        !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data seen without a read");
    valid_pulse_a: assert property (
        frame_valid_out |=> !frame_valid_out)
        else $error("frame valid longer than one cycle");
    frame_hold_a: assert property (
        !frame_valid_out |-> $stable(lane_frame_out))
        else $error("frame changed without valid");
    slot_first_a: assert property (
        frame_valid_out |-> ##2 lane_bit_out == {lane_frame_out[21],
            lane_frame_out[14], lane_frame_out[7], lane_frame_out[0]})
        else $error("first slot does not match frame");
    slot_last_a: assert property (
        frame_valid_out |-> ##8 lane_bit_out == {prev_frame_r[27],
            prev_frame_r[20], prev_frame_r[13], prev_frame_r[6]})
        else $error("last slot does not match frame");
    clk_shape_a: assert property (
        frame_valid_out |-> ##2 lvds_clock_out_a [*2]
            ##1 !lvds_clock_out_a [*3] ##1 lvds_clock_out_a [*2])
        else $error("clock lane shape wrong");
    clk_pair_a: assert property (
        lvds_clock_out_b == lvds_clock_out_a)
        else $error("clock lanes differ");
    lane_idle_a: assert property (
        frame_valid_out |-> ##9
            (lane_bit_out == 4'h0 && !lvds_clock_out_a))
        else $error("lanes not idle after frame");
    pix_latency_a: assert property (
        $rose(pclk_in) |-> ##[2:10] frame_valid_out)
        else $error("no frame after pixel clock edge");
endmodule : lpmwb_properties

bind lpmwb_top lpmwb_properties i_props (
    .mclk_in, .srst_in, .reg_rd_in, .reg_rdata_out, .pclk_in,
    .lane_frame_out, .frame_valid_out, .lane_bit_out,
    .lvds_clock_out_a, .lvds_clock_out_b
);

`default_nettype wire

/* File: lpmwb_top.sv */
// How it works
// - Output 24-bit or 18-bit colour, each with one of two lane mappings.
// - One 28-bit frame per pixel clock; clock lane goes 2 high, 3 low, 2 high.
// - Lane mapping comes from the strap pin unless a register overrides it.
// - Map high puts MSBs on lane 3; low puts LSBs there, 3-lane 18-bit.
// - Three 256-entry 8-bit tables translate red, green and blue values.
// - Every table entry can be written and read back by the host.
// - Host loads tables over the control port; this block answers as target.
// - White balance works at 24 and 18 bits; enabled by a register.
// - Six-bit input with 8-bit entries gives only 64 output values per colour.
// - While a table page is open, host accesses reach only the table.
// - Any write to address 0xFF leaves the table page.
// - After initial load and enable, further table loading is refused.
// - Reloads are accepted only after the reload enable bit is set.
// - During reload white balance stays on and output is not interrupted.
// - Reload mode accepts partial updates but table reads return zero.
// - Writing 0x70, 0xB0, 0xF0 to 0x2A opens red, green, blue table pages.
// - Writing 0x20 to 0x2A after loading enables white balance.
`include "lpmwb_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lpmwb_top (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        pclk_in,
    input  wire logic        config_strap_zero_in,
    input  wire logic [7:0]  pix_r_in,
    input  wire logic [7:0]  pix_g_in,
    input  wire logic [7:0]  pix_b_in,
    input  wire logic        pix_hs_in,
    input  wire logic        pix_vs_in,
    input  wire logic        pix_de_in,
    output logic      [27:0] lane_frame_out,
    output logic             frame_valid_out,
    output logic      [3:0]  lane_bit_out,
    output logic             lvds_clock_out_a,
    output logic             lvds_clock_out_b
);

    // Places one pixel into the four lanes, slot 0 of each lane first.
    function automatic logic [27:0] lane_frame(
        input logic [7:0] r,
        input logic [7:0] g,
        input logic [7:0] b,
        input logic [2:0] sync,
        input logic       map_hi,
        input logic       out18
    );
        logic [27:0] f;
        logic [7:0]  rr;
        logic [7:0]  gg;
        logic [7:0]  bb;
        rr = r;
        gg = g;
        bb = b;
        if (out18 && map_hi) begin
            rr = {r[7:2], 2'b00};
            gg = {g[7:2], 2'b00};
            bb = {b[7:2], 2'b00};
        end else if (out18) begin
            rr = {2'b00, r[7:2]};
            gg = {2'b00, g[7:2]};
            bb = {2'b00, b[7:2]};
        end
        if (map_hi || out18) begin
            f[6:0]   = {gg[0], rr[5:0]};
            f[13:7]  = {bb[1:0], gg[5:1]};
            f[20:14] = {sync, bb[5:2]};
            f[27:21] = {1'b0, bb[7:6], gg[7:6], rr[7:6]};
        end else begin
            f[6:0]   = {gg[2], rr[7:2]};
            f[13:7]  = {bb[3:2], gg[7:3]};
            f[20:14] = {sync, bb[7:4]};
            f[27:21] = {1'b0, bb[1:0], gg[1:0], rr[1:0]};
        end
        if (out18 && !map_hi) begin
            f[27:21] = 7'h00;
        end
        return f;
    endfunction : lane_frame

    lpmwb_lut_if lut ();

    lpmwb_lut u_lut (
        .mclk_in (mclk_in),
        .lut     (lut.ctrl)
    );

    // Pin sampling: three flip-flops, a change counts when the last two agree.
    logic [28:0] sync1_r;
    logic [28:0] sync2_r;
    logic [28:0] sync3_r;
    logic [28:0] filt_r;
    logic [28:0] filt_nxt;
    logic        pclk_prev_r;
    logic        pix_edge;

    always_comb begin
        filt_nxt = ((sync2_r ~^ sync3_r) & sync3_r)
                 | ((sync2_r ^ sync3_r) & filt_r);
        pix_edge = filt_r[0] & ~pclk_prev_r;
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sync1_r     <= '0;
            sync2_r     <= '0;
            sync3_r     <= '0;
            filt_r      <= '0;
            pclk_prev_r <= 1'b0;
        end else begin
            sync1_r     <= {config_strap_zero_in, pix_de_in, pix_vs_in,
                            pix_hs_in, pix_b_in, pix_g_in, pix_r_in,
                            pclk_in};
            sync2_r     <= sync1_r;
            sync3_r     <= sync2_r;
            filt_r      <= filt_nxt;
            pclk_prev_r <= filt_r[0];
        end
    end

    // Host register state and the table page machine.
    lpmwb_pkg::lpmwb_page_e page_r;
    lpmwb_pkg::lpmwb_page_e page_nxt;
    logic       wb_en_r;
    logic       wb_en_nxt;
    logic       reload_en_r;
    logic       reload_en_nxt;
    logic       init_done_r;
    logic       init_done_nxt;
    logic [3:0] map_ctrl_r;
    logic [3:0] map_ctrl_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       load_locked;
    logic       reload_mode;
    logic       map_hi;
    logic       in_page;

    always_comb begin
        load_locked = wb_en_r & init_done_r & ~reload_en_r;
        reload_mode = wb_en_r & reload_en_r;
        map_hi = map_ctrl_r[`LPMWB_MAP_OVR_BIT] ?
                 map_ctrl_r[`LPMWB_MAP_VAL_BIT] : filt_r[28];
        in_page = (page_r != lpmwb_pkg::LPMWB_PG_MAIN);
        page_nxt      = page_r;
        wb_en_nxt     = wb_en_r;
        reload_en_nxt = reload_en_r;
        init_done_nxt = init_done_r;
        map_ctrl_nxt  = map_ctrl_r;
        rdata_nxt     = 8'h00;
        lut.wr_en     = reg_wr_in & in_page;
        lut.wr_sel    = page_r;
        lut.rd_sel    = page_r;
        lut.addr      = reg_addr_in;
        lut.wr_data   = reg_wdata_in;
        if (reg_wr_in && in_page) begin
            if (reg_addr_in == `LPMWB_PAGE_EXIT) begin
                page_nxt = lpmwb_pkg::LPMWB_PG_MAIN;
                if (page_r == lpmwb_pkg::LPMWB_PG_BLUE) begin
                    init_done_nxt = 1'b1;
                end
            end
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `LPMWB_REG_WB_CTRL: begin
                    case (reg_wdata_in)
                        `LPMWB_CMD_RED: begin
                            if (!load_locked) begin
                                page_nxt = lpmwb_pkg::LPMWB_PG_RED;
                            end
                        end
                        `LPMWB_CMD_GREEN: begin
                            if (!load_locked) begin
                                page_nxt = lpmwb_pkg::LPMWB_PG_GREEN;
                            end
                        end
                        `LPMWB_CMD_BLUE: begin
                            if (!load_locked) begin
                                page_nxt = lpmwb_pkg::LPMWB_PG_BLUE;
                            end
                        end
                        `LPMWB_CMD_WB_ON: begin
                            wb_en_nxt = 1'b1;
                        end
                        `LPMWB_CMD_WB_OFF: begin
                            wb_en_nxt = 1'b0;
                        end
                        default: begin
                            wb_en_nxt = wb_en_r;
                        end
                    endcase
                end
                `LPMWB_REG_RELOAD: begin
                    reload_en_nxt = reg_wdata_in[`LPMWB_RELOAD_BIT];
                end
                `LPMWB_REG_MAP: begin
                    map_ctrl_nxt = reg_wdata_in[3:0];
                end
                default: begin
                    map_ctrl_nxt = map_ctrl_r;
                end
            endcase
        end
        if (reg_rd_in && in_page) begin
            rdata_nxt = reload_mode ? 8'h00 : lut.rd_data;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `LPMWB_REG_WB_CTRL: rdata_nxt = {2'b00, wb_en_r, 5'h00};
                `LPMWB_REG_RELOAD:  rdata_nxt = {7'h00, reload_en_r};
                `LPMWB_REG_MAP:     rdata_nxt = {4'h0, map_ctrl_r};
                `LPMWB_REG_STATUS:  rdata_nxt = {3'h0, page_r, map_hi,
                                                 init_done_r, wb_en_r};
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            page_r      <= lpmwb_pkg::LPMWB_PG_MAIN;
            wb_en_r     <= 1'b0;
            reload_en_r <= 1'b0;
            init_done_r <= 1'b0;
            map_ctrl_r  <= `LPMWB_MAP_RST;
            rdata_r     <= 8'h00;
        end else begin
            page_r      <= page_nxt;
            wb_en_r     <= wb_en_nxt;
            reload_en_r <= reload_en_nxt;
            init_done_r <= init_done_nxt;
            map_ctrl_r  <= map_ctrl_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;

    // Pixel pipeline: capture, table lookup, then lane mapping.
    logic [23:0] cap_rgb_r;
    logic [23:0] cap_rgb_nxt;
    logic [2:0]  cap_sync_r;
    logic [2:0]  cap_sync_nxt;
    logic        cap_v_r;
    logic [23:0] lk_rgb_r;
    logic [23:0] lk_rgb_nxt;
    logic [2:0]  lk_sync_r;
    logic        lk_v_r;
    logic [27:0] frame_r;
    logic [27:0] frame_nxt;
    logic        frame_v_r;
    logic [7:0]  in_mask;

    always_comb begin
        in_mask = map_ctrl_r[`LPMWB_MAP_IN6_BIT] ? 8'hfc : 8'hff;
        cap_rgb_nxt  = pix_edge ? (filt_r[24:1] & {3{in_mask}})
                                : cap_rgb_r;
        cap_sync_nxt = pix_edge ? filt_r[27:25] : cap_sync_r;
        lut.pix_r_idx = cap_rgb_r[7:0];
        lut.pix_g_idx = cap_rgb_r[15:8];
        lut.pix_b_idx = cap_rgb_r[23:16];
        lk_rgb_nxt = wb_en_r ? {lut.pix_b_val, lut.pix_g_val,
                                lut.pix_r_val} : cap_rgb_r;
        frame_nxt = frame_r;
        if (lk_v_r) begin
            frame_nxt = lane_frame(lk_rgb_r[7:0], lk_rgb_r[15:8],
                                   lk_rgb_r[23:16], lk_sync_r, map_hi,
                                   map_ctrl_r[`LPMWB_MAP_OUT18_BIT]);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cap_rgb_r  <= 24'h000000;
            cap_sync_r <= 3'h0;
            cap_v_r    <= 1'b0;
            lk_rgb_r   <= 24'h000000;
            lk_sync_r  <= 3'h0;
            lk_v_r     <= 1'b0;
            frame_r    <= 28'h0000000;
            frame_v_r  <= 1'b0;
        end else begin
            cap_rgb_r  <= cap_rgb_nxt;
            cap_sync_r <= cap_sync_nxt;
            cap_v_r    <= pix_edge;
            lk_rgb_r   <= lk_rgb_nxt;
            lk_sync_r  <= cap_sync_r;
            lk_v_r     <= cap_v_r;
            frame_r    <= frame_nxt;
            frame_v_r  <= lk_v_r;
        end
    end

    assign lane_frame_out  = frame_r;
    assign frame_valid_out = frame_v_r;

    // Serialiser: seven slots per frame on each lane plus the clock lane.
    logic [2:0] slot_r;
    logic [2:0] slot_nxt;
    logic       busy_r;
    logic       busy_nxt;
    logic [3:0] lane_bit_r;
    logic [3:0] lane_bit_nxt;
    logic       clk_bit_r;
    logic       clk_bit_nxt;
    logic [6:0] clk_pat;

    always_comb begin
        clk_pat      = `LPMWB_CLK_PAT;
        slot_nxt     = slot_r;
        busy_nxt     = busy_r;
        lane_bit_nxt = 4'h0;
        clk_bit_nxt  = 1'b0;
        if (frame_v_r) begin
            slot_nxt = 3'h0;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            for (int l = 0; l < `LPMWB_LANES; l++) begin
                lane_bit_nxt[l] = frame_r[l * `LPMWB_SLOTS + int'(slot_r)];
            end
            clk_bit_nxt = clk_pat[slot_r];
            slot_nxt    = slot_r + 3'h1;
            if (slot_r == `LPMWB_LAST_SLOT) begin
                busy_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            slot_r     <= 3'h0;
            busy_r     <= 1'b0;
            lane_bit_r <= 4'h0;
            clk_bit_r  <= 1'b0;
        end else begin
            slot_r     <= slot_nxt;
            busy_r     <= busy_nxt;
            lane_bit_r <= lane_bit_nxt;
            clk_bit_r  <= clk_bit_nxt;
        end
    end

    assign lane_bit_out     = lane_bit_r;
    assign lvds_clock_out_a = clk_bit_r;
    assign lvds_clock_out_b = clk_bit_r;

endmodule : lpmwb_top

`default_nettype wire

/* File: lpmwb_top_tb.sv */
`include "lpmwb_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lpmwb_top_tb;
    logic        mclk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [7:0]  reg_rdata_out;
    logic        pclk_in = 1'b0;
    logic        strap = 1'b1;
    logic [7:0]  pr = 8'h00;
    logic [7:0]  pg = 8'h00;
    logic [7:0]  pb = 8'h00;
    logic [2:0]  psync = 3'b000;
    logic [27:0] frame;
    logic        valid;
    logic [3:0]  lanes;
    logic        clk_a;
    logic [27:0] rx_frame;
    logic [15:0] rx_count;
    logic        patched = 1'b0;
    int          n_fail = 0;
    int          checks_done = 0;

    // Bus clock, and a pixel clock of unrelated phase.
    always #12.5 mclk_in = ~mclk_in;
    initial #37 forever #100 pclk_in = ~pclk_in;

    lpmwb_top i_dut (.mclk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pclk_in,
        .config_strap_zero_in(strap), .pix_r_in(pr), .pix_g_in(pg),
        .pix_b_in(pb), .pix_hs_in(psync[0]), .pix_vs_in(psync[1]),
        .pix_de_in(psync[2]), .lane_frame_out(frame),
        .frame_valid_out(valid), .lane_bit_out(lanes),
        .lvds_clock_out_a(clk_a), .lvds_clock_out_b());
    lpmwb_panel i_panel (.mclk_in, .lane_bit_in(lanes), .lane_clk_in(clk_a),
        .rx_frame_out(rx_frame), .rx_count_out(rx_count));

    // Table contents the host loads, one pattern per colour.
    function automatic logic [7:0] lut(input int c, input logic [7:0] i);
        case (c)
            0: lut = (patched && i == 8'h10) ? 8'hc3 : i ^ 8'h5a;
            1: lut = ~i;
            default: lut = i + 8'h11;
        endcase
    endfunction : lut

    // Expected lane word for the pixel now applied.
    function automatic logic [27:0] exp_frame(input logic map,
        input logic o18, input logic in6);
        logic [7:0] m;
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic [6:0] l3;
        m = in6 ? 8'hfc : 8'hff;
        r = lut(0, pr & m);
        g = lut(1, pg & m);
        b = lut(2, pb & m);
        if (o18) begin
            r = map ? r & 8'hfc : {2'b00, r[7:2]};
            g = map ? g & 8'hfc : {2'b00, g[7:2]};
            b = map ? b & 8'hfc : {2'b00, b[7:2]};
        end
        if (!map && !o18) begin
            return {1'b0, b[1:0], g[1:0], r[1:0], psync, b[7:4],
                    b[3:2], g[7:3], g[2], r[7:2]};
        end
        l3 = o18 && !map ? 7'h00 : {1'b0, b[7:6], g[7:6], r[7:6]};
        return {l3, psync, b[5:2], b[1:0], g[5:1], g[0], r[5:0]};
    endfunction : exp_frame

    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 chk({20'h00000, reg_rdata_out}, {20'h00000, e});
    endtask : rd

    // Applies one pixel and compares the frame the panel rebuilds.
    task automatic pix(input logic [7:0] r, input logic [7:0] g,
        input logic [7:0] b, input logic map, input logic o18,
        input logic in6);
        logic [15:0] n;
        @(negedge pclk_in);
        @(posedge mclk_in);
        pr    <= r;
        pg    <= g;
        pb    <= b;
        psync <= psync + 3'h3;
        n = rx_count;
        for (int k = 0; k < 200 && rx_count < n + 16'h0003; k++) begin
            @(posedge mclk_in);
        end
        // A frame that never arrives counts as a mismatch.
        if (rx_count < n + 16'h0003) begin
            n_fail++;
        end
        #1 chk(rx_frame, exp_frame(map, o18, in6));
    endtask : pix

    // Loads red, green, blue in order, then reads every entry back.
    task automatic tables();
        logic [7:0] cmd;
        for (int c = 0; c < 3; c++) begin
            cmd = c == 0 ? `LPMWB_CMD_RED :
                  c == 1 ? `LPMWB_CMD_GREEN : `LPMWB_CMD_BLUE;
            wr(`LPMWB_REG_WB_CTRL, cmd);
            for (int i = 0; i < 256; i++) begin
                wr(i[7:0], lut(c, i[7:0]));
            end
        end
        rd(`LPMWB_REG_STATUS, 8'h06);
        for (int c = 0; c < 3; c++) begin
            cmd = c == 0 ? `LPMWB_CMD_RED :
                  c == 1 ? `LPMWB_CMD_GREEN : `LPMWB_CMD_BLUE;
            wr(`LPMWB_REG_WB_CTRL, cmd);
            for (int i = 0; i < 256; i++) begin
                rd(i[7:0], lut(c, i[7:0]));
            end
            wr(`LPMWB_PAGE_EXIT, lut(c, 8'hff));
        end
    endtask : tables

    task automatic stop_test();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // Cuts a hung run short.
    initial begin
        #2000000;
        n_fail++;
        stop_test();
    end

    // Main sequence: load, enable, map in every mode, lock, reload.
    initial begin
        repeat (12) @(posedge mclk_in);
        srst_in <= 1'b0;
        #1 chk({14'h0000, lanes, clk_a, valid, reg_rdata_out}, 28'h0);
        rd(8'h40, 8'h00);
        tables();
        wr(`LPMWB_REG_WB_CTRL, `LPMWB_CMD_WB_ON);
        rd(`LPMWB_REG_WB_CTRL, 8'h20);
        rd(`LPMWB_REG_STATUS, 8'h07);
        pix(8'h3c, 8'h81, 8'hfe, 1'b1, 1'b0, 1'b0);
        @(posedge mclk_in);
        strap <= 1'b0;
        pix(8'h3c, 8'h81, 8'hfe, 1'b0, 1'b0, 1'b0);
        wr(`LPMWB_REG_MAP, 8'h03);
        pix(8'hc5, 8'h2e, 8'h97, 1'b1, 1'b0, 1'b0);
        wr(`LPMWB_REG_MAP, 8'h07);
        pix(8'hc5, 8'h2e, 8'h97, 1'b1, 1'b1, 1'b0);
        wr(`LPMWB_REG_MAP, 8'h05);
        pix(8'h6b, 8'hd3, 8'h1f, 1'b0, 1'b1, 1'b0);
        wr(`LPMWB_REG_MAP, 8'h0b);
        pix(8'h6b, 8'hd3, 8'h1f, 1'b1, 1'b0, 1'b1);
        wr(`LPMWB_REG_WB_CTRL, `LPMWB_CMD_RED);
        rd(8'h00, 8'h00);
        rd(`LPMWB_REG_STATUS, 8'h07);
        wr(`LPMWB_REG_RELOAD, 8'h01);
        wr(`LPMWB_REG_WB_CTRL, `LPMWB_CMD_RED);
        wr(8'h10, 8'hc3);
        patched = 1'b1;
        rd(8'h10, 8'h00);
        wr(`LPMWB_PAGE_EXIT, lut(0, 8'hff));
        rd(`LPMWB_REG_STATUS, 8'h07);
        wr(`LPMWB_REG_MAP, 8'h03);
        pix(8'h10, 8'h2e, 8'h97, 1'b1, 1'b0, 1'b0);
        wr(`LPMWB_REG_WB_CTRL, `LPMWB_CMD_WB_OFF);
        rd(`LPMWB_REG_WB_CTRL, 8'h00);
        stop_test();
    end
endmodule : lpmwb_top_tb

`default_nettype wire
